// File: verilog/tftc_map.vh
`ifndef TFTC_MAP_VH
`define TFTC_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define TFTC_OFF_CTRL      8'h00
`define TFTC_OFF_DELAY     8'h04
`define TFTC_OFF_WMIN      8'h08
`define TFTC_OFF_WMAX      8'h0C
`define TFTC_OFF_RATE      8'h10
`define TFTC_OFF_TRGCNT    8'h14
`define TFTC_OFF_FRMCNT    8'h18
`define TFTC_OFF_EFFRATE   8'h1C
`define TFTC_OFF_ROWS      8'h20
`define TFTC_OFF_SHUTTER   8'h24
`define TFTC_OFF_STATUS    8'h28

// ****************************************
// Control bit positions
// ****************************************
`define TFTC_BIT_INHIBIT   0
`define TFTC_BIT_FILTER    1
`define TFTC_BIT_IMMED     2
`define TFTC_BIT_AUTO      3
`define TFTC_BIT_TRGMODE   4
`define TFTC_BIT_SOFT      5
`define TFTC_CTRL_RESET    6'h08

// ****************************************
// Limits and reset values
// ****************************************
`define TFTC_DELAY_MAX     32'h003D0900
`define TFTC_WMIN_LO       32'h00000001
`define TFTC_WMIN_HI       32'h001E8480
`define TFTC_WMIN_RESET    32'h00000001
`define TFTC_WMAX_RESET    32'h001E8480
`define TFTC_RATE_MIN      32'h0000F424
`define TFTC_RATE_RESET    32'h01C9C380
`define TFTC_RATE_NUM      64'h000000E8D4A51000
`define TFTC_CNT_MAX       32'h7FFFFFFF
`define TFTC_ROWS_RESET    16'h0400
`define TFTC_SHUT_RESET    32'h00002710

// ****************************************
// Timing
// ****************************************
`define TFTC_CLK_HZ        25000000
`define TFTC_HZ_PER_MHZ    1000000
`define TFTC_US_CYC        ((`TFTC_CLK_HZ + `TFTC_HZ_PER_MHZ - 1) / `TFTC_HZ_PER_MHZ)
`define TFTC_LINE_US       32'h0000000A
`define TFTC_PRE_LINES     32'h00000002
`define TFTC_DIV_STEPS     6'h28

`endif

// File: verilog/tftc_top.v
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tftc_map.vh"

// Overview of operation
// - Inhibit set to 1 drops every trigger; 0, the default, accepts them.
// - Each accepted trigger is postponed by a programmable 0..4000000 us delay.
// - Trigger counter counts triggers leading to video, also in free-run.
// - Writing zero to either counter clears it.
// - Triggers dropped by the width filter leave the trigger counter alone.
// - Both counters wrap to zero after reaching 2147483647.
// - Frame counter counts one per image output.
// - Width filter accepts only pulses inside the window; minimum 1..2000000 us.
// - Out-of-window pulses cause no exposure and no video.
// - Software triggers bypass the width filter.
// - With filtering, exposure starts after the filter latency from pulse start.
// - Normal mode starts exposure two lines after detection, overlapping readout.
// - Immediate mode starts exposure right at trigger detection.
// - In trigger mode, immediate mode never starts exposure while readout is running; free-run starts ignore it.
// - Auto rate picks shortest cycle from shutter and rows, shutter first.
// - Auto rate exposes during output and chains outputs back to back.
// - Long shutter lowers the auto rate so exposure fits each frame.
// - Programmed rate is fps times 1000000, minimum 62500, default 30000000.
// - Rates above the row-dependent fastest rate are rejected.
// - The rate in effect under auto rate can be read back.
module tftc_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        trigger_pin,
  output reg         exposure_active,
  output reg         readout_active,
  output reg         trigger_accepted,
  output reg         frame_done
);

  // ****************************************
  // Constants
  // ****************************************
  localparam integer US_LAST_I = `TFTC_US_CYC - 1;
  localparam [4:0]  US_LAST  = US_LAST_I[4:0];
  localparam [63:0] RATE_NUM = `TFTC_RATE_NUM;
  localparam [31:0] PRE_US   = `TFTC_PRE_LINES * `TFTC_LINE_US;
  localparam [4:0]  EX_IDLE  = 5'b00001;
  localparam [4:0]  EX_DLY   = 5'b00010;
  localparam [4:0]  EX_PRE   = 5'b00100;
  localparam [4:0]  EX_ON    = 5'b01000;
  localparam [4:0]  EX_HOLD  = 5'b10000;

  // ****************************************
  // Registers
  // ****************************************
  reg  [5:0]  ctrl_r;
  reg  [31:0] delay_r;
  reg  [31:0] wmin_r;
  reg  [31:0] wmax_r;
  reg  [31:0] rate_r;
  reg  [31:0] trgcnt_r;
  reg  [31:0] frmcnt_r;
  reg  [15:0] rows_r;
  reg  [31:0] shutter_r;
  reg         soft_r;
  reg  [4:0]  presc_r;
  reg         tick_r;
  reg  [2:0]  sync_r;
  reg         meas_r;
  reg  [31:0] width_r;
  reg  [4:0]  ex_state_r;
  reg  [4:0]  ex_state_nxt;
  reg  [31:0] ex_cnt_r;
  reg  [31:0] rd_cnt_r;
  reg  [31:0] fr_cnt_r;
  reg  [32:0] rem_r;
  reg  [39:0] quo_r;
  reg  [5:0]  div_cnt_r;
  reg         div_auto_r;
  reg  [31:0] eff_rate_r;
  reg  [31:0] man_period_r;
  reg         frame_due_r;

  // ****************************************
  // Derived values
  // ****************************************
  wire        inhibit    = ctrl_r[`TFTC_BIT_INHIBIT];
  wire        filter_en  = ctrl_r[`TFTC_BIT_FILTER];
  wire        immed      = ctrl_r[`TFTC_BIT_IMMED];
  wire        auto_rate  = ctrl_r[`TFTC_BIT_AUTO];
  wire        trg_mode   = ctrl_r[`TFTC_BIT_TRGMODE];
  wire [31:0] rows32     = {16'h0000, rows_r};
  wire [31:0] readout_us = rows32 * `TFTC_LINE_US;
  wire [31:0] auto_per   = (shutter_r > readout_us) ? shutter_r : readout_us;
  wire [31:0] frame_per  = auto_rate ? auto_per :
                           ((man_period_r > auto_per) ? man_period_r : auto_per);
  wire [63:0] rate_prod  = {32'h00000000, pwdata} * {32'h00000000, readout_us};
  wire        acc_cycle  = psel & penable & pready;
  wire        wr_en      = acc_cycle & pwrite;
  wire        rise       = sync_r[1] & ~sync_r[2];
  wire        fall       = ~sync_r[1] & sync_r[2];
  wire        ex_idle    = ex_state_r == EX_IDLE;
  wire        rd_busy    = rd_cnt_r != 32'h00000000;
  wire        fr_wrap    = tick_r & (fr_cnt_r + 32'h00000001 >= frame_per);
  wire        free_start = ~trg_mode & (fr_wrap | frame_due_r) & ex_idle;
  wire        ex_enter   = (ex_state_r != EX_ON) & (ex_state_nxt == EX_ON);
  wire        ex_end     = (ex_state_r == EX_ON) & (ex_state_nxt != EX_ON);
  wire        rd_start   = ex_end ? ~rd_busy :
                           ((ex_state_r == EX_HOLD) & ~rd_busy);
  wire        rd_end     = rd_busy & tick_r & (rd_cnt_r == 32'h00000001);
  wire        w_ok       = (width_r >= wmin_r) & (width_r <= wmax_r);
  reg         trg_go;
  reg         bad_wr;
  reg         bad_rd;
  reg  [31:0] rd_mux;

  // ****************************************
  // Write validation
  // ****************************************
  always @* begin
    bad_wr = 1'b0;
    case (paddr)
      `TFTC_OFF_DELAY:  bad_wr = pwdata > `TFTC_DELAY_MAX;
      `TFTC_OFF_WMIN:   bad_wr = (pwdata < `TFTC_WMIN_LO) | (pwdata > `TFTC_WMIN_HI);
      `TFTC_OFF_RATE:   bad_wr = (pwdata < `TFTC_RATE_MIN) | (rate_prod > `TFTC_RATE_NUM);
      `TFTC_OFF_CTRL,
      `TFTC_OFF_WMAX,
      `TFTC_OFF_TRGCNT,
      `TFTC_OFF_FRMCNT,
      `TFTC_OFF_ROWS,
      `TFTC_OFF_SHUTTER: bad_wr = 1'b0;
      default:          bad_wr = 1'b1;
    endcase
  end

  // ****************************************
  // Read mux
  // ****************************************
  always @* begin
    rd_mux = 32'h00000000;
    bad_rd = 1'b0;
    case (paddr)
      `TFTC_OFF_CTRL:    rd_mux = {26'h0000000, 1'b0, ctrl_r[4:0]};
      `TFTC_OFF_DELAY:   rd_mux = delay_r;
      `TFTC_OFF_WMIN:    rd_mux = wmin_r;
      `TFTC_OFF_WMAX:    rd_mux = wmax_r;
      `TFTC_OFF_RATE:    rd_mux = rate_r;
      `TFTC_OFF_TRGCNT:  rd_mux = trgcnt_r;
      `TFTC_OFF_FRMCNT:  rd_mux = frmcnt_r;
      `TFTC_OFF_EFFRATE: rd_mux = auto_rate ? eff_rate_r : rate_r;
      `TFTC_OFF_ROWS:    rd_mux = rows32;
      `TFTC_OFF_SHUTTER: rd_mux = shutter_r;
      `TFTC_OFF_STATUS:  rd_mux = {27'h0000000, meas_r, ex_state_r == EX_HOLD,
                                   ~ex_idle, rd_busy, ex_state_r == EX_ON};
      default: begin
        rd_mux = 32'h00000000;
        bad_rd = 1'b1;
      end
    endcase
  end

  // ****************************************
  // APB slave
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
      ctrl_r    <= `TFTC_CTRL_RESET;
      delay_r   <= 32'h00000000;
      wmin_r    <= `TFTC_WMIN_RESET;
      wmax_r    <= `TFTC_WMAX_RESET;
      rate_r    <= `TFTC_RATE_RESET;
      rows_r    <= `TFTC_ROWS_RESET;
      shutter_r <= `TFTC_SHUT_RESET;
      soft_r    <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      soft_r <= 1'b0;
      if (psel & penable & ~pready) begin
        prdata  <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= pwrite ? bad_wr : bad_rd;
      end
      if (wr_en & ~bad_wr) begin
        case (paddr)
          `TFTC_OFF_CTRL: begin
            ctrl_r <= {1'b0, pwdata[4:0]};
            soft_r <= pwdata[`TFTC_BIT_SOFT];
          end
          `TFTC_OFF_DELAY:   delay_r   <= pwdata;
          `TFTC_OFF_WMIN:    wmin_r    <= pwdata;
          `TFTC_OFF_WMAX:    wmax_r    <= pwdata;
          `TFTC_OFF_RATE:    rate_r    <= pwdata;
          `TFTC_OFF_ROWS:    rows_r    <= pwdata[15:0];
          `TFTC_OFF_SHUTTER: shutter_r <= pwdata;
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // Microsecond time base and trigger sync
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= 5'h00;
      tick_r  <= 1'b0;
      sync_r  <= 3'b000;
    end else begin
      tick_r  <= presc_r == US_LAST;
      presc_r <= (presc_r == US_LAST) ? 5'h00 : presc_r + 5'h01;
      sync_r  <= {sync_r[1:0], trigger_pin};
    end
  end

  // ****************************************
  // Trigger acceptance and width filter
  // ****************************************
  always @* begin
    trg_go = 1'b0;
    if (trg_mode & ~inhibit & ex_idle) begin
      if (soft_r)
        trg_go = 1'b1;
      else if (filter_en)
        trg_go = meas_r & fall & w_ok;
      else
        trg_go = rise;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_r  <= 1'b0;
      width_r <= 32'h00000000;
    end else if (rise & filter_en & trg_mode & ~inhibit) begin
      meas_r  <= 1'b1;
      width_r <= 32'h00000000;
    end else if (meas_r & (fall | ~filter_en | inhibit)) begin
      meas_r  <= 1'b0;
    end else if (meas_r & tick_r & (width_r != `TFTC_CNT_MAX)) begin
      width_r <= width_r + 32'h00000001;
    end
  end

  // ****************************************
  // Exposure sequencer
  // ****************************************
  always @* begin
    ex_state_nxt = ex_state_r;
    case (ex_state_r)
      EX_IDLE: begin
        if (free_start)
          ex_state_nxt = EX_ON;
        else if (trg_go)
          ex_state_nxt = EX_DLY;
      end
      EX_DLY: begin
        if (ex_cnt_r >= delay_r)
          ex_state_nxt = EX_PRE;
      end
      EX_PRE: begin
        if (immed)
          ex_state_nxt = rd_busy ? EX_PRE : EX_ON;
        else if (ex_cnt_r >= PRE_US)
          ex_state_nxt = EX_ON;
      end
      EX_ON: begin
        if (tick_r & (ex_cnt_r + 32'h00000001 >= shutter_r))
          ex_state_nxt = rd_busy ? EX_HOLD : EX_IDLE;
      end
      EX_HOLD: begin
        if (~rd_busy)
          ex_state_nxt = EX_IDLE;
      end
      default: ex_state_nxt = EX_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ex_state_r <= EX_IDLE;
      ex_cnt_r   <= 32'h00000000;
    end else begin
      ex_state_r <= ex_state_nxt;
      if (ex_state_nxt != ex_state_r)
        ex_cnt_r <= 32'h00000000;
      else if (tick_r & (ex_cnt_r != `TFTC_CNT_MAX))
        ex_cnt_r <= ex_cnt_r + 32'h00000001;
    end
  end

  // ****************************************
  // Readout and free-run timer
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_cnt_r    <= 32'h00000000;
      fr_cnt_r    <= 32'h00000000;
      frame_due_r <= 1'b0;
    end else begin
      frame_due_r <= ~trg_mode & (fr_wrap | frame_due_r) & ~free_start;
      if (rd_start)
        rd_cnt_r <= (readout_us == 32'h00000000) ? 32'h00000001 : readout_us;
      else if (rd_busy & tick_r)
        rd_cnt_r <= rd_cnt_r - 32'h00000001;
      if (trg_mode | fr_wrap)
        fr_cnt_r <= 32'h00000000;
      else if (tick_r)
        fr_cnt_r <= fr_cnt_r + 32'h00000001;
    end
  end

  // ****************************************
  // Counters and output flags
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trgcnt_r         <= 32'h00000000;
      frmcnt_r         <= 32'h00000000;
      exposure_active  <= 1'b0;
      readout_active   <= 1'b0;
      trigger_accepted <= 1'b0;
      frame_done       <= 1'b0;
    end else begin
      exposure_active  <= ex_state_nxt == EX_ON;
      readout_active   <= rd_start | (rd_busy & ~rd_end);
      trigger_accepted <= ex_enter;
      frame_done       <= rd_end;
      if (ex_enter)
        trgcnt_r <= (trgcnt_r == `TFTC_CNT_MAX) ? 32'h00000000 :
                    ((wr_en & (paddr == `TFTC_OFF_TRGCNT) & (pwdata == 32'h00000000)) ?
                     32'h00000001 : trgcnt_r + 32'h00000001);
      else if (wr_en & (paddr == `TFTC_OFF_TRGCNT) & (pwdata == 32'h00000000))
        trgcnt_r <= 32'h00000000;
      if (rd_end)
        frmcnt_r <= (frmcnt_r == `TFTC_CNT_MAX) ? 32'h00000000 :
                    ((wr_en & (paddr == `TFTC_OFF_FRMCNT) & (pwdata == 32'h00000000)) ?
                     32'h00000001 : frmcnt_r + 32'h00000001);
      else if (wr_en & (paddr == `TFTC_OFF_FRMCNT) & (pwdata == 32'h00000000))
        frmcnt_r <= 32'h00000000;
    end
  end

  // ****************************************
  // Rate divider
  // ****************************************
  wire [31:0] divisor = div_auto_r ? ((auto_per == 32'h00000000) ? 32'h00000001 : auto_per)
                                   : rate_r;
  wire [33:0] rem_sh  = {rem_r, quo_r[39]};
  wire        sub_ok  = rem_sh >= {2'b00, divisor};
  wire [33:0] rem_sub = rem_sh - {2'b00, divisor};
  wire [31:0] quo_sat = (quo_r[39:32] != 8'h00) ? 32'hFFFFFFFF : quo_r[31:0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_r        <= 33'h000000000;
      quo_r        <= 40'h0000000000;
      div_cnt_r    <= 6'h00;
      div_auto_r   <= 1'b1;
      eff_rate_r   <= 32'h00000000;
      man_period_r <= 32'h00000000;
    end else if (div_cnt_r == 6'h00) begin
      if (div_auto_r)
        eff_rate_r   <= quo_sat;
      else
        man_period_r <= quo_sat;
      div_auto_r <= auto_rate;
      rem_r      <= 33'h000000000;
      quo_r      <= RATE_NUM[39:0];
      div_cnt_r  <= `TFTC_DIV_STEPS;
    end else begin
      rem_r     <= sub_ok ? rem_sub[32:0] : rem_sh[32:0];
      quo_r     <= {quo_r[38:0], sub_ok};
      div_cnt_r <= div_cnt_r - 6'h01;
    end
  end

endmodule // tftc_top

`default_nettype wire

// File: tb/tftc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module tftc_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        trigger_pin,
  input wire logic        exposure_active,
  input wire logic        readout_active,
  input wire logic        trigger_accepted,
  input wire logic        frame_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait:
    assert property (psel && penable && !pready |=> pready) else $error("no ready");
  a_ready_once:
    assert property (pready |=> !pready) else $error("ready too long");
  a_ready_cause:
    assert property (pready |-> psel && penable && $past(psel)) else $error("stray ready");
  a_write_zero:
    assert property (pready && pwrite |-> prdata == 32'h0) else $error("write data");
  a_err_zero:
    assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
  a_accept_once:
    assert property (trigger_accepted |=> !trigger_accepted) else $error("accept long");
  a_accept_expose:
    assert property (trigger_accepted |-> $rose(exposure_active)) else $error("no expose");
  a_done_once:
    assert property (frame_done |=> !frame_done) else $error("done long");
  a_done_readout:
    assert property (frame_done |-> $past(readout_active)) else $error("done no readout");
endmodule // tftc_asserts
bind tftc_top tftc_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .trigger_pin(trigger_pin),
  .exposure_active(exposure_active), .readout_active(readout_active),
  .trigger_accepted(trigger_accepted), .frame_done(frame_done));
`default_nettype wire

// File: tb/tftc_trig_src.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// External trigger source
// ****
module tftc_trig_src (
  input  wire logic pclk,
  output var  logic trigger_pin
);
  initial trigger_pin = 1'b0;
  // Active-high pulse of n cycles
  task automatic pulse(input int n);
    @(posedge pclk);
    trigger_pin <= 1'b1;
    repeat (n) @(posedge pclk);
    trigger_pin <= 1'b0;
  endtask
endmodule // tftc_trig_src
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tftc_map.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
  // ****
  // Bench
  // ****
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         trigger_pin;
  wire         exposure_active;
  wire         readout_active;
  wire         trigger_accepted;
  wire         frame_done;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          n_acc = 0;
  int          n_frm = 0;
  int          b_acc;
  int          b_frm;
  int          lat;

  always #20 pclk = ~pclk;

  tftc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_pin(trigger_pin), .exposure_active(exposure_active),
    .readout_active(readout_active), .trigger_accepted(trigger_accepted),
    .frame_done(frame_done));
  tftc_trig_src u_src (.pclk(pclk), .trigger_pin(trigger_pin));

  always @(posedge pclk) begin
    if (trigger_accepted === 1'b1) n_acc <= n_acc + 1;
    if (frame_done === 1'b1) n_frm <= n_frm + 1;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    `CHK("pready wait", 2, n)
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write, or read and compare with d
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(w, a, d, r, e);
    `CHK("pslverr", xe, e)
    if (!w) `CHK("prdata", d, r)
  endtask

  task automatic wait_idle;
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, `TFTC_OFF_STATUS, 32'h00000000, r, e);
      n++;
    end while (r[4:1] !== 4'h0 && n < 3000);
    `CHK("idle", 4'h0, r[4:1])
  endtask

  task automatic seen(input int lim, output int l);
    l = -1;
    for (int i = 0; i < lim && l < 0; i++) begin
      @(posedge pclk);
      if (trigger_accepted === 1'b1) l = i;
    end
  endtask

  // Pulse of w us; accept latency must lie in [lo, hi]
  task automatic trg(input int w, input int lo, input int hi);
    int l;
    wait_idle;
    fork
      u_src.pulse(w * `TFTC_US_CYC);
      seen(1000, l);
    join
    `CHK("latency in window", 1'b1, l >= lo && l <= hi)
  endtask

  task automatic t_regs;
    logic [7:0]  adr [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24};
    logic [31:0] val [7] = '{32'h00000008, 32'h00000000, 32'h00000001, 32'h001E8480,
                             32'h01C9C380, 32'h00000400, 32'h00002710};
    for (int i = 0; i < 7; i++) bus(1'b0, adr[i], val[i], 1'b0);
    bus(1'b1, `TFTC_OFF_SHUTTER, 32'h00000002, 1'b0);
    bus(1'b1, `TFTC_OFF_ROWS, 32'h00000001, 1'b0);
    bus(1'b0, 8'h2C, 32'h00000000, 1'b1);
    bus(1'b1, `TFTC_OFF_EFFRATE, 32'h00000001, 1'b1);
    bus(1'b1, `TFTC_OFF_DELAY, 32'h003D0901, 1'b1);
    bus(1'b1, `TFTC_OFF_DELAY, 32'h003D0900, 1'b0);
    bus(1'b1, `TFTC_OFF_DELAY, 32'h00000000, 1'b0);
    bus(1'b1, `TFTC_OFF_WMIN, 32'h00000000, 1'b1);
    bus(1'b1, `TFTC_OFF_WMIN, 32'h001E8481, 1'b1);
    bus(1'b1, `TFTC_OFF_RATE, 32'h0000F423, 1'b1);
    bus(1'b1, `TFTC_OFF_RATE, 32'h05F5E100, 1'b0);
    bus(1'b1, `TFTC_OFF_RATE, 32'h05D21DBA, 1'b0);
    $display("t_regs done");
  endtask

  task automatic t_count;
    bus(1'b1, `TFTC_OFF_CTRL, 32'h00000018, 1'b0);
    wait_idle;
    bus(1'b1, `TFTC_OFF_TRGCNT, 32'h00000000, 1'b0);
    bus(1'b1, `TFTC_OFF_FRMCNT, 32'h00000000, 1'b0);
    bus(1'b1, `TFTC_OFF_TRGCNT, 32'h00000005, 1'b0);
    bus(1'b0, `TFTC_OFF_TRGCNT, 32'h00000000, 1'b0);
    bus(1'b0, `TFTC_OFF_FRMCNT, 32'h00000000, 1'b0);
    b_acc = n_acc;
    b_frm = n_frm;
    $display("t_count done");
  endtask

  task automatic t_trig;
    bus(1'b1, `TFTC_OFF_CTRL, 32'h0000001C, 1'b0);
    trg(2, 2, 12);
    wait (readout_active === 1'b1);
    fork
      u_src.pulse(`TFTC_US_CYC);
      seen(1000, lat);
    join
    `CHK("accept after readout", 1'b1, lat >= 200 && lat <= 300)
    bus(1'b1, `TFTC_OFF_DELAY, 32'h00000004, 1'b0);
    trg(2, 75, 130);
    bus(1'b1, `TFTC_OFF_DELAY, 32'h00000000, 1'b0);
    bus(1'b1, `TFTC_OFF_CTRL, 32'h00000018, 1'b0);
    trg(2, 475, 530);
    bus(1'b1, `TFTC_OFF_CTRL, 32'h0000001D, 1'b0);
    trg(2, -1, -1);
    $display("t_trig done");
  endtask

  task automatic t_filter;
    bus(1'b1, `TFTC_OFF_WMIN, 32'h00000003, 1'b0);
    bus(1'b1, `TFTC_OFF_WMAX, 32'h00000005, 1'b0);
    bus(1'b1, `TFTC_OFF_CTRL, 32'h0000001E, 1'b0);
    trg(1, -1, -1);
    trg(8, -1, -1);
    trg(4, 100, 140);
    wait_idle;
    fork
      bus(1'b1, `TFTC_OFF_CTRL, 32'h0000003E, 1'b0);
      seen(200, lat);
    join
    `CHK("soft accepted", 1'b1, lat >= 0)
    $display("t_filter done");
  endtask

  task automatic t_free;
    int f0;
    f0 = n_frm;
    bus(1'b1, `TFTC_OFF_SHUTTER, 32'h000000FA, 1'b0);
    bus(1'b1, `TFTC_OFF_CTRL, 32'h00000008, 1'b0);
    repeat (32000) @(posedge pclk);
    bus(1'b0, `TFTC_OFF_EFFRATE, 32'hEE6B2800, 1'b0);
    `CHK("free frames", 1'b1, n_frm - f0 >= 3)
    bus(1'b1, `TFTC_OFF_SHUTTER, 32'h00000002, 1'b0);
    bus(1'b1, `TFTC_OFF_ROWS, 32'h0000001E, 1'b0);
    repeat (200) @(posedge pclk);
    bus(1'b0, `TFTC_OFF_EFFRATE, 32'hC6AEA155, 1'b0);
    bus(1'b1, `TFTC_OFF_CTRL, 32'h00000018, 1'b0);
    wait_idle;
    bus(1'b0, `TFTC_OFF_TRGCNT, 32'(n_acc - b_acc), 1'b0);
    bus(1'b0, `TFTC_OFF_FRMCNT, 32'(n_frm - b_frm), 1'b0);
    bus(1'b1, `TFTC_OFF_CTRL, 32'h00000010, 1'b0);
    bus(1'b0, `TFTC_OFF_EFFRATE, 32'h05D21DBA, 1'b0);
    $display("t_free done");
  endtask

  initial begin
    repeat (80000) @(posedge pclk);
    n_mismatch++;
    $display("[ERR] timeout exp 0 got 1");
    report_and_stop;
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_count;
    t_trig;
    t_filter;
    t_free;
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
